// ---- shared/ansbk_pkg.sv ----
package ansbk_pkg;
   // Five-bit character width and message store size
   localparam int CHAR_W = 5;
   localparam int STORE_DEPTH = 21;
   localparam int PTR_W = 5;
   localparam logic [4:0] PTR_LAST = 5'h14;
   localparam logic [4:0] PTR_START = 5'h00;
   // Character codes, blocked bit is 0 (spacing)
   localparam logic [4:0] CODE_LTRS = 5'h1F;
   localparam logic [4:0] CODE_FIGS = 5'h1B;
   localparam logic [4:0] CODE_D = 5'h09;
   localparam logic [4:0] CODE_CR = 5'h08;
   localparam logic [4:0] CODE_LF = 5'h02;
   // Serial frame: start, five data, stop
   localparam int FRAME_BITS = 7;
   localparam logic [2:0] BIT_LAST = 3'h6;
   // Bit time 22 ms at 10 MHz
   localparam int BIT_TIME_US = 22000;
   localparam int CLK_MHZ = 10;
   localparam int BIT_CYCLES = BIT_TIME_US * CLK_MHZ;
   // Buffer shape
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_AW = 5;
   // Transmitter states
   typedef enum logic [1:0] {
      ANSBK_TX_IDLE = 2'b00,
      ANSBK_TX_SHIFT = 2'b01
   } ansbk_tx_state_t;
endpackage : ansbk_pkg

// ---- shared/ansbk_stream_if.sv ----
`timescale 1ns/1ps
interface ansbk_stream_if;
   logic valid;
   logic ready;
   logic [4:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ansbk_stream_if

// ---- verilog/ansbk_fifo.sv ----
`timescale 1ns/1ps
module ansbk_fifo #(
   parameter int WIDTH = 5,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   ansbk_stream_if.snk in_s,
   ansbk_stream_if.src out_s
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic full;
   logic empty;
   logic push;
   logic pop;
   logic [WIDTH-1:0] dout_reg;

   // Extra pointer bit separates full from empty
   assign full = (wr_reg[AW-1:0] == rd_reg[AW-1:0]) && (wr_reg[AW] != rd_reg[AW]);
   assign empty = (wr_reg == rd_reg);
   assign push = in_s.valid && !full;
   assign pop = out_s.ready && !empty;
   assign in_s.ready = !full;
   assign out_s.valid = !empty;
   assign out_s.data = mem[rd_reg[AW-1:0]];

   // Storage write
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_s.data;
      end
   end

   // Pointers
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pop) begin
            rd_reg <= rd_reg + 1'b1;
         end
      end
   end
endmodule : ansbk_fifo

// ---- verilog/ansbk_sequencer.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Received FIGS clears inhibit flag
// - Received D, inhibit clear, triggers sequence
// - Triggering D locks keyboard if fitted
// - Manual key triggers same sequence locally
// - Message store holds 21 configured positions
// - First character always LTRS
// - Stored five-bit code loads keyboard register
// - Blocked bit spacing, unblocked bit marking
// - Pointer advances once per character cycle
// - Cycles back to back for 21 positions
// - Back at LTRS start: stop, park
// - Keyboard stays locked until manual unlock
// - Idle store never touches typed characters
// - Local transmit cycle sets inhibit flag
// - Stop element always marking
module ansbk_sequencer #(
   parameter int BIT_CYCLES = ansbk_pkg::BIT_CYCLES,
   parameter logic [104:0] MSG_CFG = {
      {16{ansbk_pkg::CODE_LTRS}},
      ansbk_pkg::CODE_LF,
      ansbk_pkg::CODE_CR,
      ansbk_pkg::CODE_LF,
      ansbk_pkg::CODE_CR,
      ansbk_pkg::CODE_LTRS}
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rx_valid_i,
   input wire logic [4:0] rx_char_i,
   input wire logic key_valid_i,
   input wire logic [4:0] key_char_i,
   output logic key_ready_o,
   input wire logic manual_answerback_key_i,
   input wire logic kbd_unlock_i,
   input wire logic lock_fitted_i,
   output logic line_o,
   output logic kbd_locked_o,
   output logic seq_active_o,
   output logic inhibit_o,
   output logic [4:0] msg_ptr_o
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////
   ansbk_stream_if fifo_in ();
   ansbk_stream_if fifo_out ();
   logic [4:0] store [ansbk_pkg::STORE_DEPTH];
   logic [4:0] ptr_reg;
   logic [4:0] ptr_next;
   logic active_reg;
   logic inhibit_reg;
   logic locked_reg;
   logic [4:0] code_reg;
   logic [4:0] code_next;
   logic [6:0] frame_reg;
   logic [2:0] bit_reg;
   logic [31:0] tick_reg;
   logic line_reg;
   ansbk_pkg::ansbk_tx_state_t state_reg;
   logic manual_s1_reg;
   logic manual_s2_reg;
   logic manual_s3_reg;
   logic unlock_s1_reg;
   logic unlock_s2_reg;
   logic fitted_s1_reg;
   logic fitted_s2_reg;
   logic manual_rise;
   logic rx_figs;
   logic rx_d;
   logic trigger;
   logic tx_idle;
   logic cycle_start;
   logic bit_end;
   logic frame_end;

   // Wrap-around step through the message store
   function automatic logic [4:0] ansbk_ptr_step(input logic [4:0] p);
      if (p == ansbk_pkg::PTR_LAST) begin
         return ansbk_pkg::PTR_START;
      end
      return p + 5'h01;
   endfunction : ansbk_ptr_step

   ////////////////////////////////////////////////////////////////////////
   // Message store and pin synchronisers
   ////////////////////////////////////////////////////////////////////////
   // Store content fixed by configuration; slot 0 forced to LTRS
   always_comb begin
      for (int i = 0; i < ansbk_pkg::STORE_DEPTH; i++) begin
         store[i] = MSG_CFG[i*5 +: 5];
      end
      store[0] = ansbk_pkg::CODE_LTRS;
   end

   // Key and straps come from pins
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         manual_s1_reg <= 1'b0;
         manual_s2_reg <= 1'b0;
         manual_s3_reg <= 1'b0;
         unlock_s1_reg <= 1'b0;
         unlock_s2_reg <= 1'b0;
         fitted_s1_reg <= 1'b0;
         fitted_s2_reg <= 1'b0;
      end else begin
         manual_s1_reg <= manual_answerback_key_i;
         manual_s2_reg <= manual_s1_reg;
         manual_s3_reg <= manual_s2_reg;
         unlock_s1_reg <= kbd_unlock_i;
         unlock_s2_reg <= unlock_s1_reg;
         fitted_s1_reg <= lock_fitted_i;
         fitted_s2_reg <= fitted_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger detection
   ////////////////////////////////////////////////////////////////////////
   assign manual_rise = manual_s2_reg && !manual_s3_reg;
   assign rx_figs = rx_valid_i && (rx_char_i == ansbk_pkg::CODE_FIGS);
   assign rx_d = rx_valid_i && (rx_char_i == ansbk_pkg::CODE_D);
   // D with inhibit clear triggers; manual key likewise
   assign trigger = !active_reg && ((rx_d && !inhibit_reg) || manual_rise);

   // Inhibit flag; a local cycle start wins over a FIGS in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         inhibit_reg <= 1'b0;
      end else if (cycle_start && !active_reg && !trigger) begin
         inhibit_reg <= 1'b1;
      end else if (rx_figs) begin
         inhibit_reg <= 1'b0;
      end
   end

   // Keyboard lock; unlock only by the manual command
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         locked_reg <= 1'b0;
      end else if (rx_d && !inhibit_reg && !active_reg && fitted_s2_reg) begin
         locked_reg <= 1'b1;
      end else if (unlock_s2_reg) begin
         locked_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequence control
   ////////////////////////////////////////////////////////////////////////
   assign tx_idle = (state_reg == ansbk_pkg::ANSBK_TX_IDLE);
   // Sequence owns the transmitter; typed characters wait behind it
   assign cycle_start = tx_idle && (active_reg || trigger || (fifo_out.valid && !locked_reg));

   always_comb begin
      ptr_next = ptr_reg;
      if (cycle_start && (active_reg || trigger)) begin
         ptr_next = ansbk_ptr_step(ptr_reg);
      end
   end

   // Pointer and active flag
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ptr_reg <= ansbk_pkg::PTR_START;
         active_reg <= 1'b0;
      end else begin
         ptr_reg <= ptr_next;
         if (trigger) begin
            // start immediately, run back to back
            active_reg <= 1'b1;
         end else if (cycle_start && active_reg && (ptr_next == ansbk_pkg::PTR_START)) begin
            active_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Keyboard code register and serial transmitter
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      code_next = code_reg;
      if (cycle_start) begin
         if (active_reg || trigger) begin
            code_next = store[ptr_reg];
         end else begin
            code_next = fifo_out.data;
         end
      end
   end

   // Typed characters drain only into a free transmitter
   assign fifo_out.ready = tx_idle && !active_reg && !trigger && !locked_reg;
   assign fifo_in.valid = key_valid_i;
   assign fifo_in.data = key_char_i;
   assign key_ready_o = fifo_in.ready && !locked_reg;
   assign bit_end = (tick_reg == 32'(BIT_CYCLES - 1));
   assign frame_end = bit_end && (bit_reg == ansbk_pkg::BIT_LAST);

   // Frame shifter
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_reg <= ansbk_pkg::ANSBK_TX_IDLE;
         code_reg <= ansbk_pkg::CODE_LTRS;
         frame_reg <= 7'h7F;
         bit_reg <= 3'h0;
         tick_reg <= 32'h00000000;
      end else begin
         code_reg <= code_next;
         unique case (state_reg)
            ansbk_pkg::ANSBK_TX_IDLE: begin
               if (cycle_start) begin
                  // bit value is line level; stop marking
                  frame_reg <= {1'b1, code_next, 1'b0};
                  bit_reg <= 3'h0;
                  tick_reg <= 32'h00000000;
                  state_reg <= ansbk_pkg::ANSBK_TX_SHIFT;
               end
            end
            ansbk_pkg::ANSBK_TX_SHIFT: begin
               if (bit_end) begin
                  tick_reg <= 32'h00000000;
                  bit_reg <= bit_reg + 3'h1;
                  frame_reg <= {1'b1, frame_reg[6:1]};
                  if (frame_end) begin
                     state_reg <= ansbk_pkg::ANSBK_TX_IDLE;
                  end
               end else begin
                  tick_reg <= tick_reg + 32'h00000001;
               end
            end
         endcase
      end
   end

   // Registered line; marking at rest
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         line_reg <= 1'b1;
      end else if (state_reg == ansbk_pkg::ANSBK_TX_SHIFT && !frame_end) begin
         line_reg <= bit_end ? frame_reg[1] : frame_reg[0];
      end else if (cycle_start) begin
         line_reg <= 1'b0;
      end else begin
         line_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Typed-character buffer and outputs
   ////////////////////////////////////////////////////////////////////////
   ansbk_fifo #(
      .WIDTH(ansbk_pkg::CHAR_W),
      .DEPTH(ansbk_pkg::FIFO_DEPTH),
      .AW(ansbk_pkg::FIFO_AW)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_s(fifo_in),
      .out_s(fifo_out)
   );

   assign line_o = line_reg;
   assign kbd_locked_o = locked_reg;
   assign seq_active_o = active_reg;
   assign inhibit_o = inhibit_reg;
   assign msg_ptr_o = ptr_reg;
endmodule : ansbk_sequencer

// ---- testbench/ansbk_sequencer_sva.sv ----
`timescale 1ns/1ps
module ansbk_seq_sva #(
   parameter int BIT_CYCLES = 4
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic rx_valid_i,
   input wire logic [4:0] rx_char_i,
   input wire logic kbd_unlock_i,
   input wire logic key_ready_o,
   input wire logic line_o,
   input wire logic kbd_locked_o,
   input wire logic seq_active_o,
   input wire logic inhibit_o,
   input wire logic [4:0] msg_ptr_o
);
   int fr_cnt;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   // Frame position counter; falls inside a frame are data bits, not starts
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fr_cnt <= 0;
      end else if (fr_cnt != 0) begin
         fr_cnt <= (fr_cnt == 7 * BIT_CYCLES) ? 0 : fr_cnt + 1;
      end else if ($fell(line_o)) begin
         fr_cnt <= 1;
      end
   end
   ////////////////////////////////////////
   // Past-reset guards stop a one-edge reset from faking a change
   trig_start_a: assert property (
      rx_valid_i && rx_char_i == ansbk_pkg::CODE_D && !inhibit_o && !seq_active_o |=> seq_active_o)
      else $error("D did not trigger");
   seq_start_a: assert property ($rose(seq_active_o) |-> ##[0:1] !line_o)
      else $error("No frame at trigger");
   park_zero_a: assert property (!seq_active_o |-> msg_ptr_o == ansbk_pkg::PTR_START)
      else $error("Idle pointer not parked");
   ptr_step_a: assert property ($changed(msg_ptr_o) && !$past(rst_i) |->
      msg_ptr_o == (($past(msg_ptr_o) == ansbk_pkg::PTR_LAST) ? 5'h00 : $past(msg_ptr_o) + 5'h01))
      else $error("Pointer step wrong");
   stop_mark_a: assert property (fr_cnt >= 6 * BIT_CYCLES |-> line_o)
      else $error("Stop element not marking");
   inh_set_a: assert property ($rose(inhibit_o) |-> ##[0:1] !line_o)
      else $error("Inhibit set without transmit");
   inh_clr_a: assert property ($fell(inhibit_o) && !$past(rst_i) |->
      $past(rx_valid_i) && $past(rx_char_i) == ansbk_pkg::CODE_FIGS)
      else $error("Inhibit cleared without FIGS");
   lock_ready_a: assert property (kbd_locked_o |-> !key_ready_o)
      else $error("Keyboard ready while locked");
   unlock_src_a: assert property ($fell(kbd_locked_o) && !$past(rst_i) |->
      $past(kbd_unlock_i, 2) || $past(kbd_unlock_i, 3) || $past(kbd_unlock_i, 4))
      else $error("Lock cleared without unlock");
   cover property ($fell(seq_active_o));
   cover property ($fell(kbd_locked_o));
   cover property ($fell(inhibit_o));
endmodule : ansbk_seq_sva
bind ansbk_sequencer ansbk_seq_sva #(.BIT_CYCLES(BIT_CYCLES)) ansbk_seq_sva_inst (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
   .kbd_unlock_i(kbd_unlock_i), .key_ready_o(key_ready_o), .line_o(line_o), .kbd_locked_o(kbd_locked_o),
   .seq_active_o(seq_active_o), .inhibit_o(inhibit_o), .msg_ptr_o(msg_ptr_o));

// ---- testbench/ansbk_remote_model.sv ----
`timescale 1ns/1ps
module ansbk_remote_model #(
   parameter int BIT_CYCLES = 4
) (
   input wire logic core_clk_i,
   input wire logic line_i,
   output int got_cnt_o,
   output logic [4:0] got_o [0:79],
   output int stop_err_o
);
   logic [4:0] code_reg;
   initial begin
      got_cnt_o = 0;
      stop_err_o = 0;
   end
   ////////////////////////////////////////
   // Far printer: sample mid-element on the falling edge, clear of the launch edge
   always begin
      @(negedge core_clk_i iff line_i === 1'b0);
      repeat (BIT_CYCLES / 2) @(negedge core_clk_i);
      for (int i = 0; i < 5; i++) begin
         repeat (BIT_CYCLES) @(negedge core_clk_i);
         code_reg[i] = line_i;
      end
      repeat (BIT_CYCLES) @(negedge core_clk_i);
      if (line_i !== 1'b1) stop_err_o++;
      got_o[got_cnt_o] = code_reg;
      got_cnt_o++;
   end
endmodule : ansbk_remote_model

// ---- testbench/test_ansbk_sequencer.sv ----
`timescale 1ns/1ps
module test_ansbk_sequencer;
   localparam int BC = 4;
   // CR LF framing, 16 text slots, slot 0 left blank
   function automatic logic [104:0] msg_cfg();
      logic [104:0] m;
      m = 105'h0;
      m[14:5] = {ansbk_pkg::CODE_LF, ansbk_pkg::CODE_CR};
      for (int i = 3; i < 19; i++) m[5*i+:5] = 5'(i) ^ 5'h15;
      m[104:95] = {ansbk_pkg::CODE_LF, ansbk_pkg::CODE_CR};
      return m;
   endfunction : msg_cfg
   localparam logic [104:0] MSG = msg_cfg();
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rx_valid_i = 1'b0;
   logic [4:0] rx_char_i = 5'h00;
   logic key_valid_i = 1'b0;
   logic [4:0] key_char_i = 5'h00;
   logic man_key_i = 1'b0;
   logic kbd_unlock_i = 1'b0;
   logic lock_fitted_i = 1'b1;
   logic key_ready_o, line_o, kbd_locked_o, seq_active_o, inhibit_o;
   logic [4:0] msg_ptr_o;
   logic [4:0] got [0:79];
   int got_cnt, stop_err, mismatches = 0, n_compared = 0, cycles = 0;
   ansbk_sequencer #(.BIT_CYCLES(BC), .MSG_CFG(MSG)) ansbk_sequencer_inst (.core_clk_i(core_clk_i),
      .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i), .key_valid_i(key_valid_i),
      .key_char_i(key_char_i), .key_ready_o(key_ready_o), .manual_answerback_key_i(man_key_i),
      .kbd_unlock_i(kbd_unlock_i), .lock_fitted_i(lock_fitted_i), .line_o(line_o),
      .kbd_locked_o(kbd_locked_o), .seq_active_o(seq_active_o), .inhibit_o(inhibit_o), .msg_ptr_o(msg_ptr_o));
   ansbk_remote_model #(.BIT_CYCLES(BC)) ansbk_remote_model_inst (.core_clk_i(core_clk_i), .line_i(line_o),
      .got_cnt_o(got_cnt), .got_o(got), .stop_err_o(stop_err));
   ////////////////////////////////////////
   // Clock and hang guard, ceiling well above the about 2260 cycles of work
   always #50 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   // One-cycle receive pulse; the code lines change afterwards so nothing stale lingers
   task automatic send_rx(input logic [4:0] code);
      @(negedge core_clk_i);
      rx_valid_i = 1'b1;
      rx_char_i = code;
      @(negedge core_clk_i);
      rx_valid_i = 1'b0;
      rx_char_i = ~code;
   endtask : send_rx
   task automatic expect_frame(input int idx, input logic [4:0] code);
      for (int i = 0; i < 60 && got_cnt <= idx; i++) @(posedge core_clk_i);
      check(got[idx] === code, "frame code");
   endtask : expect_frame
   task automatic run_store(input int base);
      for (int k = 0; k < 21; k++) begin
         expect_frame(base + k, (k == 0) ? ansbk_pkg::CODE_LTRS : MSG[5*k+:5]);
      end
      check(seq_active_o === 1'b0 && msg_ptr_o === 5'h00 && stop_err == 0, "park");
   endtask : run_store
   ////////////////////////////////////////
   // Scenarios
   task automatic t_typed();
      check({line_o, kbd_locked_o, seq_active_o, inhibit_o, msg_ptr_o} === {1'b1, 8'h00}, "reset");
      @(negedge core_clk_i);
      key_char_i = 5'h0A;
      key_valid_i = 1'b1;
      @(negedge core_clk_i);
      key_valid_i = 1'b0;
      key_char_i = 5'h15;
      expect_frame(0, 5'h0A);
      check(inhibit_o === 1'b1 && seq_active_o === 1'b0, "typed");
      send_rx(ansbk_pkg::CODE_D);
      check(seq_active_o === 1'b0 && inhibit_o === 1'b1, "D refused");
      send_rx(ansbk_pkg::CODE_FIGS);
      check(inhibit_o === 1'b0, "FIGS clear");
      $display("done typed");
   endtask : t_typed
   task automatic t_remote();
      send_rx(ansbk_pkg::CODE_D);
      check(seq_active_o === 1'b1 && kbd_locked_o === 1'b1, "trigger");
      run_store(1);
      repeat (60) @(posedge core_clk_i);
      check(got_cnt == 22 && kbd_locked_o === 1'b1 && key_ready_o === 1'b0, "stay");
      @(negedge core_clk_i);
      kbd_unlock_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      kbd_unlock_i = 1'b0;
      lock_fitted_i = 1'b0;
      repeat (4) @(negedge core_clk_i);
      check(kbd_locked_o === 1'b0 && key_ready_o === 1'b1, "unlock");
      $display("done remote");
   endtask : t_remote
   // Typed traffic fills the buffer while the store runs, then drains after it
   task automatic t_manual();
      int n;
      man_key_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      man_key_i = 1'b0;
      check(seq_active_o === 1'b1 && kbd_locked_o === 1'b0, "manual");
      n = 0;
      key_valid_i = 1'b1;
      while (key_ready_o === 1'b1 && n < 40) begin
         key_char_i = 5'(n);
         @(negedge core_clk_i);
         n++;
      end
      key_valid_i = 1'b0;
      key_char_i = ~key_char_i;
      check(n == ansbk_pkg::FIFO_DEPTH, "fill");
      run_store(22);
      for (int k = 0; k < 32; k++) expect_frame(43 + k, 5'(k));
      check(inhibit_o === 1'b1, "inhibit");
      $display("done manual");
   endtask : t_manual
   initial begin
      repeat (5) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge core_clk_i);
      t_typed();
      t_remote();
      t_manual();
      finish_test();
   end
endmodule : test_ansbk_sequencer
